// >>> metering_irq_pkg.sv
// Package with SFR map, field positions and carriers for metering interrupts
package metering_irq_pkg;

  // SFR addresses of the enable and status registers
  localparam logic [7:0] ADDR_ENABLE_LOW = 8'hD9;
  localparam logic [7:0] ADDR_ENABLE_MID = 8'hDA;
  localparam logic [7:0] ADDR_ENABLE_HIGH = 8'hDB;
  localparam logic [7:0] ADDR_STATUS_LOW = 8'hDC;
  localparam logic [7:0] ADDR_STATUS_MID = 8'hDD;
  localparam logic [7:0] ADDR_STATUS_HIGH = 8'hDE;

  // Values after reset
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_STATUS_LOW = 8'h00;
  localparam logic [7:0] RST_STATUS_MID = 8'h00;
  localparam logic [7:0] RST_STATUS_HIGH = 8'h80;
  localparam logic [7:0] RST_READ = 8'h00;

  // Writable and gateable bits of each register
  localparam logic [7:0] MASK_LOW = 8'h3F;
  localparam logic [7:0] MASK_MID = 8'hFF;
  localparam logic [7:0] MASK_HIGH_EN = 8'h3F;
  localparam logic [7:0] MASK_HIGH_ST = 8'hBF;

  // Field positions
  localparam int COMBINED_BIT = 7;
  localparam int FAULT_BIT = 5;
  localparam int REACTIVE_SIGN_BIT = 4;
  localparam int ACTIVE_SIGN_BIT = 3;
  localparam int APPARENT_NOLOAD_BIT = 2;
  localparam int REACTIVE_NOLOAD_BIT = 1;
  localparam int ACTIVE_NOLOAD_BIT = 0;
  localparam int RESET_END_BIT = 7;
  localparam int CFG_FAULT_BIT = 6;
  localparam int CFG_REACTIVE_BIT = 5;
  localparam int CFG_ACTIVE_BIT = 4;

  // One SFR access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic read;
    logic [7:0] wdata;
  } sfr_req_type;

  // Event pulses and levels from the metering signal path
  typedef struct packed {
    logic faultMode;
    logic reactiveNeg;
    logic activeNeg;
    logic apparentNoload;
    logic currentRmsNoload;
    logic reactiveNoload;
    logic activeNoload;
    logic pulseOutTwo;
    logic pulseOutOne;
    logic [2:0] energyOverflow;
    logic [2:0] energyHalf;
    logic softResetEnd;
    logic waveformReady;
    logic currentPeak;
    logic voltagePeak;
    logic lineCycleDone;
    logic zeroCrossTimeout;
    logic zeroCross;
  } meter_event_type;

endpackage

// >>> metering_interrupt_flags.sv
// Metering interrupt status, enable and combined pending interrupt logic
//
// Operation
// RL1 - Combined flag, status low bit 7, sets when any enabled flag is set.
// RL2 - Combined flag clears itself once all enabled flags are cleared.
// RL3 - Status low bit 5 sets on fault-mode change in configured direction.
// RL4 - Status low bit 4 sets on reactive sign change in configured direction.
// RL5 - Status low bit 3 sets on active sign change in configured direction.
// RL6 - Status low bit 2 sets on apparent or current rms no-load.
// RL7 - Status low bit 1 sets on reactive power no-load.
// RL8 - Status low bit 0 sets on active power no-load.
// RL9 - Status mid bit 7 sets on every second-output pulse, even if disabled.
// RL10 - Status mid bit 6 sets on every first-output pulse, even if disabled.
// RL11 - Status mid bits 5,4,3 set on apparent, reactive, active overflow.
// RL12 - Status mid bits 2,1,0 set on apparent, reactive, active half full.
// RL13 - Status high bit 7 sets at the end of any hardware or software reset.
// RL14 - Status high bit 5 sets when new waveform samples are loaded.
// RL15 - Status high bits 4 and 3 set on current and voltage peak.
// RL16 - Status high bit 2 sets when line-cycle accumulation finishes.
// RL17 - Status high bit 1 sets on zero-crossing timeout.
// RL18 - Status high bit 0 sets on each voltage zero crossing.
// RL19 - Status low bits 5..0 raise pending when matching enable bit set.
// RL20 - Output pulse flags raise pending through enable mid bits 7 and 6.
// RL21 - Status mid bits 5..1 raise pending through matching enable bits.
// RL22 - Active energy half-full raises pending through enable mid bit 0.
// RL23 - Enable high at 0xDB gates status high bits 5..0 into pending.
// RL24 - Config bit 6 picks fault entry (0) or return to normal (1).
// RL25 - Config bit 4 picks active sign positive-to-negative (0) or reverse.
// RL26 - Each status flag except the combined flag stays set until software clears it.
// RL27 - Pending interrupt is a level while the combined flag is set.
`timescale 1ns/1ps

module metering_interrupt_flags
  import metering_irq_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire sfr_req_type sfrReq,
  input wire meter_event_type meterEvt,
  input wire logic [7:0] accumulationConfig,
  output logic [7:0] sfrRdata,
  output logic irqPending
);

  // Software clear keeps bits written one, clears bits written zero;
  // a new event in the same cycle wins over the clear.
  function automatic logic [7:0] clearSet(
    input logic [7:0] cur,
    input logic wr,
    input logic [7:0] data,
    input logic [7:0] set,
    input logic [7:0] mask
  );
    logic [7:0] kept;
    kept = wr ? (cur & data) : cur;
    return (kept | set) & mask;
  endfunction

  logic [7:0] enLow_r;
  logic [7:0] enMid_r;
  logic [7:0] enHigh_r;
  logic [7:0] stLow_r;
  logic [7:0] stMid_r;
  logic [7:0] stHigh_r;
  logic [7:0] stLow_nxt;
  logic [7:0] stMid_nxt;
  logic [7:0] stHigh_nxt;
  logic combined_r;
  logic combined_nxt;
  logic faultPrev_r;
  logic reactivePrev_r;
  logic activePrev_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Address decode of the SFR port
  wire hitEnLow = sfrReq.addr == ADDR_ENABLE_LOW;
  wire hitEnMid = sfrReq.addr == ADDR_ENABLE_MID;
  wire hitEnHigh = sfrReq.addr == ADDR_ENABLE_HIGH;
  wire hitStLow = sfrReq.addr == ADDR_STATUS_LOW;
  wire hitStMid = sfrReq.addr == ADDR_STATUS_MID;
  wire hitStHigh = sfrReq.addr == ADDR_STATUS_HIGH;
  wire wrStLow = sfrReq.write && hitStLow;
  wire wrStMid = sfrReq.write && hitStMid;
  wire wrStHigh = sfrReq.write && hitStHigh;

  // Direction-selected sign and fault change events
  wire faultEnter = meterEvt.faultMode && !faultPrev_r;
  wire faultLeave = !meterEvt.faultMode && faultPrev_r;
  wire faultEvt = accumulationConfig[CFG_FAULT_BIT] ? // RL24
    faultLeave : faultEnter; // RL3
  wire reacToNeg = meterEvt.reactiveNeg && !reactivePrev_r;
  wire reacToPos = !meterEvt.reactiveNeg && reactivePrev_r;
  wire reacEvt = accumulationConfig[CFG_REACTIVE_BIT] ?
    reacToPos : reacToNeg; // RL4
  wire actToNeg = meterEvt.activeNeg && !activePrev_r;
  wire actToPos = !meterEvt.activeNeg && activePrev_r;
  wire actEvt = accumulationConfig[CFG_ACTIVE_BIT] ? // RL25
    actToPos : actToNeg; // RL5

  // Set vectors for each status register
  wire [7:0] setLow = {
    2'b00,
    faultEvt, // RL3
    reacEvt, // RL4
    actEvt, // RL5
    meterEvt.apparentNoload || meterEvt.currentRmsNoload, // RL6
    meterEvt.reactiveNoload, // RL7
    meterEvt.activeNoload // RL8
  };
  wire [7:0] setMid = {
    meterEvt.pulseOutTwo, // RL9
    meterEvt.pulseOutOne, // RL10
    meterEvt.energyOverflow, // RL11
    meterEvt.energyHalf // RL12
  };
  wire [7:0] setHigh = {
    meterEvt.softResetEnd, // RL13
    1'b0,
    meterEvt.waveformReady, // RL14
    meterEvt.currentPeak, // RL15
    meterEvt.voltagePeak, // RL15
    meterEvt.lineCycleDone, // RL16
    meterEvt.zeroCrossTimeout, // RL17
    meterEvt.zeroCross // RL18
  };

  // Sticky status flags with software clear
  assign stLow_nxt = clearSet(stLow_r, wrStLow, sfrReq.wdata, setLow,
    MASK_LOW); // RL26
  assign stMid_nxt = clearSet(stMid_r, wrStMid, sfrReq.wdata, setMid,
    MASK_MID); // RL26
  assign stHigh_nxt = clearSet(stHigh_r, wrStHigh, sfrReq.wdata, setHigh,
    MASK_HIGH_ST); // RL26

  // Enabled flags combined into one pending term
  wire [7:0] gatedLow = stLow_r & enLow_r & MASK_LOW; // RL19
  wire [7:0] gatedMid = stMid_r & enMid_r; // RL20 RL21 RL22
  wire [7:0] gatedHigh = stHigh_r & enHigh_r & MASK_HIGH_EN; // RL23
  assign combined_nxt = |{gatedLow, gatedMid, gatedHigh}; // RL1 RL2

  // Read multiplexer; unmapped addresses read zero
  wire [7:0] statusLowView = {combined_r, stLow_r[6:0]};
  assign rdata_nxt =
    !sfrReq.read ? rdata_r :
    hitEnLow ? enLow_r :
    hitEnMid ? enMid_r :
    hitEnHigh ? enHigh_r :
    hitStLow ? statusLowView :
    hitStMid ? stMid_r :
    hitStHigh ? stHigh_r :
    RST_READ;

  // Enable registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enLow_r <= RST_ENABLE;
      enMid_r <= RST_ENABLE;
      enHigh_r <= RST_ENABLE;
    end else begin
      if (sfrReq.write && hitEnLow) enLow_r <= sfrReq.wdata & MASK_LOW;
      if (sfrReq.write && hitEnMid) enMid_r <= sfrReq.wdata;
      if (sfrReq.write && hitEnHigh) begin
        enHigh_r <= sfrReq.wdata & MASK_HIGH_EN;
      end
    end
  end

  // Status registers; reset leaves the reset-end flag set
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stLow_r <= RST_STATUS_LOW;
      stMid_r <= RST_STATUS_MID;
      stHigh_r <= RST_STATUS_HIGH; // RL13
    end else begin
      stLow_r <= stLow_nxt;
      stMid_r <= stMid_nxt;
      stHigh_r <= stHigh_nxt;
    end
  end

  // Previous levels for change detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      faultPrev_r <= 1'b0;
      reactivePrev_r <= 1'b0;
      activePrev_r <= 1'b0;
    end else begin
      faultPrev_r <= meterEvt.faultMode;
      reactivePrev_r <= meterEvt.reactiveNeg;
      activePrev_r <= meterEvt.activeNeg;
    end
  end

  // Combined flag, pending level and read data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      combined_r <= 1'b0;
      irqPending <= 1'b0;
      rdata_r <= RST_READ;
    end else begin
      combined_r <= combined_nxt; // RL1 RL2
      irqPending <= combined_nxt; // RL27
      rdata_r <= rdata_nxt;
    end
  end

  assign sfrRdata = rdata_r;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence lowEnabledSet;
    |(stLow_r & enLow_r & MASK_LOW);
  endsequence

  sequence pendingRaised;
    ##1 combined_r && irqPending;
  endsequence

  combined_set_a: assert property ( // RL1
    lowEnabledSet |-> pendingRaised)
    else $error("Combined flag missed an enabled low flag");

  combined_clear_a: assert property ( // RL2
    !(|{stLow_r & enLow_r & MASK_LOW, stMid_r & enMid_r,
        stHigh_r & enHigh_r & MASK_HIGH_EN}) |=> !combined_r)
    else $error("Combined flag stayed set with no enabled flag");

  pending_level_a: assert property ( // RL27
    irqPending == combined_r)
    else $error("Pending output differs from combined flag");

  fault_dir_a: assert property ( // RL24
    (!accumulationConfig[CFG_FAULT_BIT] && meterEvt.faultMode &&
     !$past(meterEvt.faultMode)) |=> stLow_r[FAULT_BIT])
    else $error("Fault entry did not set fault flag");

  active_sign_a: assert property ( // RL25
    (accumulationConfig[CFG_ACTIVE_BIT] && !meterEvt.activeNeg &&
     $past(meterEvt.activeNeg)) |=> stLow_r[ACTIVE_SIGN_BIT])
    else $error("Active sign return did not set its flag");

  pulse_flag_a: assert property ( // RL9
    meterEvt.pulseOutTwo |=> stMid_r[7])
    else $error("Second pulse flag not set");

  set_wins_a: assert property ( // RL26
    (wrStMid && meterEvt.energyHalf[0]) |=> stMid_r[0])
    else $error("Clear beat a same-cycle half-full event");

  sticky_flag_a: assert property ( // RL26
    (stHigh_r[0] && !wrStHigh) |=> stHigh_r[0])
    else $error("Zero-cross flag dropped without a clear");

  zero_cross_a: assert property ( // RL18
    meterEvt.zeroCross |=> stHigh_r[0] ##1 (stHigh_r[0] || $past(wrStHigh)))
    else $error("Zero-cross flag not set by crossing");

  high_gate_a: assert property ( // RL23
    (stHigh_r[2] && enHigh_r[2]) |=> combined_r)
    else $error("Line-cycle flag not gated into pending");

  noload_a: assert property ( // RL6
    meterEvt.currentRmsNoload |=> stLow_r[APPARENT_NOLOAD_BIT])
    else $error("Rms no-load did not set apparent no-load flag");

  fault_leave_a: assert property ( // RL3
    (accumulationConfig[CFG_FAULT_BIT] && !meterEvt.faultMode &&
     $past(meterEvt.faultMode)) |=> stLow_r[FAULT_BIT])
    else $error("Return to normal did not set fault flag");

  reactive_neg_a: assert property ( // RL4
    (!accumulationConfig[CFG_REACTIVE_BIT] && meterEvt.reactiveNeg &&
     !$past(meterEvt.reactiveNeg)) |=> stLow_r[REACTIVE_SIGN_BIT])
    else $error("Reactive sign drop did not set its flag");

  reactive_pos_a: assert property ( // RL4
    (accumulationConfig[CFG_REACTIVE_BIT] && !meterEvt.reactiveNeg &&
     $past(meterEvt.reactiveNeg)) |=> stLow_r[REACTIVE_SIGN_BIT])
    else $error("Reactive sign return did not set its flag");

  active_neg_a: assert property ( // RL5
    (!accumulationConfig[CFG_ACTIVE_BIT] && meterEvt.activeNeg &&
     !$past(meterEvt.activeNeg)) |=> stLow_r[ACTIVE_SIGN_BIT])
    else $error("Active sign drop did not set its flag");

  apparent_noload_a: assert property ( // RL6
    meterEvt.apparentNoload |=> stLow_r[APPARENT_NOLOAD_BIT])
    else $error("Apparent no-load did not set its flag");

  reactive_noload_a: assert property ( // RL7
    meterEvt.reactiveNoload |=> stLow_r[REACTIVE_NOLOAD_BIT])
    else $error("Reactive no-load did not set its flag");

  active_noload_a: assert property ( // RL8
    meterEvt.activeNoload |=> stLow_r[ACTIVE_NOLOAD_BIT])
    else $error("Active no-load did not set its flag");

  pulse_one_a: assert property ( // RL10
    meterEvt.pulseOutOne |=> stMid_r[6])
    else $error("First pulse flag not set");

  overflow_flags_a: assert property ( // RL11
    (|meterEvt.energyOverflow) |=>
    ((stMid_r[5:3] & $past(meterEvt.energyOverflow)) ==
     $past(meterEvt.energyOverflow)))
    else $error("Energy overflow flag not set");

  half_flags_a: assert property ( // RL12
    (|meterEvt.energyHalf) |=>
    ((stMid_r[2:0] & $past(meterEvt.energyHalf)) ==
     $past(meterEvt.energyHalf)))
    else $error("Energy half-full flag not set");

  reset_end_a: assert property ( // RL13
    meterEvt.softResetEnd |=> stHigh_r[RESET_END_BIT])
    else $error("Software reset end did not set reset flag");

  waveform_flag_a: assert property ( // RL14
    meterEvt.waveformReady |=> stHigh_r[5])
    else $error("Waveform ready flag not set");

  peak_flags_a: assert property ( // RL15
    (meterEvt.currentPeak || meterEvt.voltagePeak) |=>
    ((stHigh_r[4] || !$past(meterEvt.currentPeak)) &&
     (stHigh_r[3] || !$past(meterEvt.voltagePeak))))
    else $error("Peak flag not set");

  cycle_done_a: assert property ( // RL16
    meterEvt.lineCycleDone |=> stHigh_r[2])
    else $error("Line-cycle done flag not set");

  zero_timeout_a: assert property ( // RL17
    meterEvt.zeroCrossTimeout |=> stHigh_r[1])
    else $error("Zero-cross timeout flag not set");

  low_gate_a: assert property ( // RL19
    (stLow_r[ACTIVE_NOLOAD_BIT] && enLow_r[ACTIVE_NOLOAD_BIT]) |=>
    combined_r)
    else $error("Active no-load flag not gated into pending");

  pulse_gate_a: assert property ( // RL20
    ((stMid_r[7] && enMid_r[7]) || (stMid_r[6] && enMid_r[6])) |=>
    combined_r)
    else $error("Pulse flag not gated into pending");

  overflow_gate_a: assert property ( // RL21
    (stMid_r[3] && enMid_r[3]) |=> combined_r)
    else $error("Active overflow flag not gated into pending");

  half_gate_a: assert property ( // RL22
    (stMid_r[0] && enMid_r[0]) |=> combined_r)
    else $error("Active half-full flag not gated into pending");

  status_read_a: assert property ( // RL1
    (sfrReq.read && hitStLow) |=>
    (sfrRdata[COMBINED_BIT] == $past(combined_r)))
    else $error("Status low read lost the combined flag");

endmodule // metering_interrupt_flags

// >>> core_irq_model.sv
// Core-side model that counts entries into the pending interrupt
`timescale 1ns/1ps

module core_irq_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic irqPending,
  output logic [7:0] entryCount
);
  logic seen_r;

  // Count each rise of the pending level, as the core would vector once
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seen_r <= 1'b0;
      entryCount <= 8'h00;
    end else begin
      seen_r <= irqPending;
      if (irqPending && !seen_r) begin
        entryCount <= entryCount + 8'h01;
      end
    end
  end

endmodule // core_irq_model

// >>> tb_metering_interrupt_flags.sv
// Self-checking testbench for the metering interrupt flag block
`timescale 1ns/1ps

module tb_metering_interrupt_flags;
  import metering_irq_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  sfr_req_type req = '0;
  meter_event_type evt = '0;
  logic [7:0] accCfg = 8'h00;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] entries;
  int nMismatch = 0;
  int checked = 0;
  logic [7:0] a;
  logic [7:0] v;

  metering_interrupt_flags u_dut (.mclk(mclk), .rstn(rstn), .sfrReq(req),
    .meterEvt(evt), .accumulationConfig(accCfg), .sfrRdata(rdata),
    .irqPending(irq));
  core_irq_model u_core (.mclk(mclk), .rstn(rstn), .irqPending(irq),
    .entryCount(entries));

  // 25 MHz core clock
  always #20 mclk = ~mclk;

  // Wait edges, then step just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic tally(input string what, input logic [7:0] e,
    input logic [7:0] s);
    checked++;
    if (s !== e) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  // Write strobe for one edge, then one idle edge
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    req = '{addr: ad, write: 1'b1, read: 1'b0, wdata: d};
    tick(1);
    req.write = 1'b0;
    tick(1);
  endtask

  task automatic expRd(input logic [7:0] ad, input logic [7:0] e);
    req = '{addr: ad, write: 1'b0, read: 1'b1, wdata: 8'h00};
    tick(1);
    req.read = 1'b0;
    tally($sformatf("sfr %h", ad), e, rdata);
    tick(1);
  endtask

  task automatic expIrq(input logic e);
    tally("irqPending", {7'h00, e}, {7'h00, irq});
  endtask

  // One-cycle event pulse; flag lands, then pending follows
  task automatic pulse(input int i);
    evt[i] = 1'b1;
    tick(1);
    evt[i] = 1'b0;
    tick(1);
  endtask

  // Status register and flag value raised by pulse bit i
  function automatic logic [15:0] evtMap(input int i);
    if (i < 7)
      return {ADDR_STATUS_HIGH, (i == 6) ? 8'h80 : 8'h01 << i};
    if (i < 15)
      return {ADDR_STATUS_MID, 8'h01 << (i - 7)};
    return {ADDR_STATUS_LOW, (i < 17) ? 8'h01 << (i - 15) : 8'h04};
  endfunction

  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    tick(5);
    rstn = 1'b1;
    tick(1);
    expRd(ADDR_ENABLE_MID, 8'h00);
    expRd(ADDR_STATUS_MID, 8'h00);
    expRd(ADDR_STATUS_HIGH, 8'h80);
    expRd(8'hDF, 8'h00);
    expIrq(1'b0);
    wr(ADDR_ENABLE_LOW, 8'hFF);
    wr(ADDR_ENABLE_HIGH, 8'hFF);
    wr(ADDR_STATUS_LOW, 8'hFF);
    expRd(ADDR_ENABLE_LOW, 8'h3F);
    expRd(ADDR_ENABLE_HIGH, 8'h3F);
    expRd(ADDR_STATUS_LOW, 8'h00);
    expIrq(1'b0);
    wr(ADDR_STATUS_HIGH, 8'h00);
    $display("test reset and access done");
    // Every pulse event: latched while masked, gated only by its own bit, except reset end, which never raises pending
    for (int i = 0; i < 19; i++) begin
      {a, v} = evtMap(i);
      wr(a - 8'h03, ~v);
      pulse(i);
      expRd(a, v);
      expIrq(1'b0);
      wr(a - 8'h03, 8'hFF);
      expIrq(a != ADDR_STATUS_HIGH || i < 6);
      expRd(ADDR_STATUS_LOW, ((a == ADDR_STATUS_LOW) ? v : 8'h00) |
        ((a != ADDR_STATUS_HIGH || i < 6) ? 8'h80 : 8'h00));
      wr(a, 8'h00);
      expIrq(1'b0);
    end
    tally("core entries", 8'h12, entries);
    $display("test pulse events done");
    // Sign and fault levels in both configured directions
    wr(ADDR_ENABLE_LOW, 8'h00);
    for (int j = 0; j < 3; j++) begin
      v = 8'h20 >> j;
      for (int d = 0; d < 2; d++) begin
        accCfg = d ? (8'h40 >> j) : 8'h00;
        evt[21 - j] = 1'b1;
        tick(2);
        expRd(ADDR_STATUS_LOW, d ? 8'h00 : v);
        wr(ADDR_STATUS_LOW, 8'h00);
        evt[21 - j] = 1'b0;
        tick(2);
        expRd(ADDR_STATUS_LOW, d ? v : 8'h00);
        wr(ADDR_STATUS_LOW, 8'h00);
      end
    end
    $display("test sign levels done");
    // Event in the same cycle as its clear still lands
    evt[7] = 1'b1;
    req = '{addr: ADDR_STATUS_MID, write: 1'b1, read: 1'b0, wdata: 8'h00};
    tick(1);
    evt[7] = 1'b0;
    req.write = 1'b0;
    tick(1);
    expRd(ADDR_STATUS_MID, 8'h01);
    expIrq(1'b1);
    $display("test set over clear done");
    // Second reset in mid-run brings back the reset-end flag
    rstn = 1'b0;
    tick(2);
    rstn = 1'b1;
    tick(1);
    expRd(ADDR_STATUS_HIGH, 8'h80);
    expIrq(1'b0);
    $display("test second reset done");
    giveVerdict;
  end

  // Cuts a hang short
  initial begin
    repeat (5000) @(posedge mclk);
    nMismatch++;
    giveVerdict;
  end

endmodule // tb_metering_interrupt_flags
